// file: vco_cal_map.vh
`ifndef VCO_CAL_MAP_VH
`define VCO_CAL_MAP_VH
// Register byte offsets
`define REG_CTRL          8'h00
`define REG_CORE          8'h04
`define REG_BAND          8'h08
`define REG_AMP           8'h0c
`define REG_LOCK_DLY      8'h10
`define REG_LOCK_CFG      8'h14
`define REG_STATUS        8'h18
`define REG_IRQ_STAT      8'h1c
`define REG_IRQ_MASK      8'h20
`define REG_RESULT        8'h24
// Control register fields
`define CTRL_FCAL_BIT     0
`define CTRL_STATUS_SEL   2
`define CTRL_MUTE_BIT     9
`define CTRL_WD_EN_BIT    10
`define CTRL_CLKDIV_LSB   11
`define CTRL_CLKDIV_MSB   13
`define CTRL_LIMIT_LSB    16
`define CTRL_LIMIT_MSB    18
`define CTRL_FORCE_LSB    20
`define CTRL_FORCE_MSB    22
`define CTRL_RESET        32'h0000_0000
`define CORE_RESET        3'h7
`define BAND_RESET        8'h00
`define AMP_RESET         9'h000
`define LOCK_DLY_RESET    16'h0000
`define CLKDIV_MAX        3'h4
// Band search space, one octave from 7600 to 15200 MHz
`define VCO_MIN_MHZ       15'd7600
`define VCO_MAX_MHZ       15'd15200
`define CORE_MAX          3'h7
`define BAND_MAX          8'hff
`define AMP_MAX           9'h1ff
// Watchdog and band step timing, in state machine ticks
`define WD_TICKS          12'h800
// A band step must outlast the synchroniser delay of the band flag
`define STEP_TICKS        4'h4
// Interrupt bits
`define IRQ_CAL_DONE      0
`define IRQ_WD_RESTART    1
`define IRQ_WD_FAIL       2
`define IRQ_LOCK_LOST     3
`define IRQ_RECAL         4
`define IRQ_WIDTH         5
`endif

// file: tick_divider.v
`timescale 1ns/1ps
`include "vco_cal_map.vh"
module tick_divider (
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Control
   input  wire [2:0] div_exp,
   // Output
   output reg        tick
);
   reg  [15:0] count;
   wire [15:0] limit;
   // Divide by 2^div_exp, clamped at 16
   assign limit = (div_exp > `CLKDIV_MAX) ? 16'h000f : ((16'h0001 << div_exp) - 16'h0001);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else if (count >= limit) begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

// file: vco_calibration_lock_detect.v
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "vco_cal_map.vh"
module vco_calibration_lock_detect (
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Analog side
   input  wire        reference_input,
   input  wire        pd_tick,
   input  wire        pll_locked,
   input  wire        band_high,
   input  wire        amp_ok,
   input  wire        relock_recal_enable,
   // Status and outputs
   input  wire        readback_data,
   output reg         shared_status_pin,
   output reg         output_mute,
   output reg  [2:0]  core_sel,
   output reg  [7:0]  band_sel,
   output reg  [8:0]  amp_sel,
   output wire        irq
);
   localparam ST_IDLE = 3'h0;
   localparam ST_BAND = 3'h1;
   localparam ST_AMP  = 3'h2;
   localparam ST_DONE = 3'h3;
   localparam ST_FAIL = 3'h4;

   reg  [31:0] ctrl;
   reg  [2:0]  core_start;
   reg  [7:0]  band_value;
   reg  [8:0]  amplitude_value;
   reg  [15:0] lock_delay_count;
   reg         lock_indicator_select;
   reg  [`IRQ_WIDTH-1:0] irq_stat;
   reg  [`IRQ_WIDTH-1:0] irq_mask;
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [11:0] wd_count;
   reg  [2:0]  restart_count;
   reg  [3:0]  step;
   reg  [15:0] dly_count;
   reg         dly_done;
   reg  [15:0] unlock_count;
   reg         cal_req;
   reg         band_req;
   reg         amp_only;
   reg         combined;
   reg  [2:0]  ref_sync;
   reg  [2:0]  lock_sync;
   reg  [2:0]  band_sync;
   reg  [2:0]  amp_sync;
   reg  [2:0]  pd_sync;
   reg         pd_prev;
   reg  [7:0]  ref_watch;
   reg         ref_prev;
   reg         ref_valid;
   reg         lock_ok;
   reg         band_hi;
   reg         amp_good;

   wire        sm_tick;
   wire        wr;
   wire        rd;
   wire        wr_ctrl;
   wire        busy;
   wire        band_force;
   wire        amplitude_force;
   wire        core_force;
   wire        wd_en;
   wire        pd_edge;
   wire        recal_fire;
   wire        wd_expire;
   wire        cal_ind;
   wire [`IRQ_WIDTH-1:0] ev;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & penable & ~pwrite;
   assign wr_ctrl = wr & (paddr == `REG_CTRL);
   assign core_force      = ctrl[`CTRL_FORCE_LSB];
   assign band_force      = ctrl[`CTRL_FORCE_LSB+1];
   assign amplitude_force = ctrl[`CTRL_FORCE_MSB];
   assign wd_en   = ctrl[`CTRL_WD_EN_BIT];
   assign busy    = (state == ST_BAND) | (state == ST_AMP);

   tick_divider u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .div_exp (ctrl[`CTRL_CLKDIV_MSB:`CTRL_CLKDIV_LSB]),
      .tick    (sm_tick)
   );

   // Pin inputs: three stages, change once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_sync  <= 3'h0;
         lock_sync <= 3'h0;
         band_sync <= 3'h0;
         amp_sync  <= 3'h0;
         pd_sync   <= 3'h0;
         lock_ok   <= 1'b0;
         band_hi   <= 1'b0;
         amp_good  <= 1'b0;
         pd_prev   <= 1'b0;
      end else begin
         ref_sync  <= {ref_sync[1:0], reference_input};
         lock_sync <= {lock_sync[1:0], pll_locked};
         band_sync <= {band_sync[1:0], band_high};
         amp_sync  <= {amp_sync[1:0], amp_ok};
         pd_sync   <= {pd_sync[1:0], pd_tick};
         if (lock_sync[2] == lock_sync[1])
            lock_ok <= lock_sync[2];
         if (band_sync[2] == band_sync[1])
            band_hi <= band_sync[2];
         if (amp_sync[2] == amp_sync[1])
            amp_good <= amp_sync[2];
         if (pd_sync[2] == pd_sync[1])
            pd_prev <= pd_sync[2];
      end
   end
   assign pd_edge = (pd_sync[2] == pd_sync[1]) & pd_sync[2] & ~pd_prev;

   // Reference presence: edge seen within a short window
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev  <= 1'b0;
         ref_watch <= 8'h00;
         ref_valid <= 1'b0;
      end else begin
         if (ref_sync[2] == ref_sync[1])
            ref_prev <= ref_sync[2];
         if ((ref_sync[2] == ref_sync[1]) && (ref_sync[2] != ref_prev)) begin
            ref_watch <= 8'h00;
            ref_valid <= 1'b1;
         end else if (ref_watch == 8'hff) begin
            ref_valid <= 1'b0;
         end else begin
            ref_watch <= ref_watch + 8'h01;
         end
      end
   end

   // Registers and calibration requests
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl                  <= `CTRL_RESET;
         core_start            <= `CORE_RESET;
         band_value            <= `BAND_RESET;
         amplitude_value       <= `AMP_RESET;
         lock_delay_count      <= `LOCK_DLY_RESET;
         lock_indicator_select <= 1'b0;
         irq_mask              <= {`IRQ_WIDTH{1'b0}};
         cal_req               <= 1'b0;
         band_req              <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl     <= pwdata;
            cal_req  <= 1'b1;
            band_req <= pwdata[`CTRL_FCAL_BIT];
         end else if (recal_fire) begin
            cal_req  <= 1'b1;
            band_req <= 1'b1;
         end else if (sm_tick) begin
            cal_req  <= 1'b0;
         end
         if (wr && paddr == `REG_CORE)
            core_start <= pwdata[2:0];
         if (wr && paddr == `REG_BAND)
            band_value <= pwdata[7:0];
         if (wr && paddr == `REG_AMP)
            amplitude_value <= pwdata[8:0];
         if (wr && paddr == `REG_LOCK_DLY)
            lock_delay_count <= pwdata[15:0];
         if (wr && paddr == `REG_LOCK_CFG)
            lock_indicator_select <= pwdata[0];
         if (wr && paddr == `REG_IRQ_MASK)
            irq_mask <= pwdata[`IRQ_WIDTH-1:0];
      end
   end

   // Calibration state machine on the divided tick
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE, ST_DONE, ST_FAIL: begin
            if (cal_req)
               next_state = (band_req && !band_force) ? ST_BAND : ST_AMP;
         end
         ST_BAND: begin
            if (wd_expire)
               next_state = (restart_count < ctrl[`CTRL_LIMIT_MSB:`CTRL_LIMIT_LSB]) ? ST_BAND : ST_FAIL;
            else if (step == `STEP_TICKS && !band_hi)
               next_state = ST_AMP;
         end
         ST_AMP: begin
            if (wd_expire)
               next_state = (restart_count < ctrl[`CTRL_LIMIT_MSB:`CTRL_LIMIT_LSB]) ? ST_BAND : ST_FAIL;
            else if (amplitude_force || amp_good || amp_sel == `AMP_MAX)
               next_state = ST_DONE;
         end
         default: next_state = ST_IDLE;
      endcase
   end
   assign wd_expire = wd_en & (wd_count == `WD_TICKS);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= ST_IDLE;
         wd_count      <= 12'h000;
         restart_count <= 3'h0;
         step          <= 4'h0;
         core_sel      <= `CORE_RESET;
         band_sel      <= `BAND_RESET;
         amp_sel       <= `AMP_RESET;
         amp_only      <= 1'b0;
      end else if (sm_tick) begin
         state <= next_state;
         wd_count <= busy ? wd_count + 12'h001 : 12'h000;
         if ((state == ST_IDLE || state == ST_DONE || state == ST_FAIL) && cal_req) begin
            restart_count <= 3'h0;
            wd_count      <= 12'h000;
            step          <= 4'h0;
            amp_only      <= ~(band_req && !band_force);
            // Amplitude-only runs keep the band already found, unless the core or the band is forced
            if (band_req || band_force || core_force) begin
               core_sel <= core_start;
               band_sel <= band_force ? band_value : `BAND_RESET;
            end
            amp_sel       <= amplitude_force ? amplitude_value : `AMP_RESET;
         end else if (busy && wd_expire) begin
            if (next_state == ST_BAND)
               restart_count <= restart_count + 3'h1;
            wd_count      <= 12'h000;
            step          <= 4'h0;
            if (!band_force)
               band_sel <= `BAND_RESET;
         end else if (state == ST_BAND) begin
            // Search up through bands, then cores, across 7600 to 15200 MHz
            if (step != `STEP_TICKS) begin
               step <= step + 4'h1;
            end else begin
               step <= 4'h0;
               if (band_hi && band_sel != `BAND_MAX) begin
                  band_sel <= band_sel + 8'h01;
               end else if (band_hi && core_sel != `CORE_MAX && !core_force) begin
                  core_sel <= core_sel + 3'h1;
                  band_sel <= `BAND_RESET;
               end
            end
         end else if (state == ST_AMP && !amplitude_force && !amp_good && amp_sel != `AMP_MAX) begin
            amp_sel <= amp_sel + 9'h001;
         end
      end
   end

   // Lock delay after calibration, counted in phase detector cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_count    <= 16'h0000;
         dly_done     <= 1'b0;
         unlock_count <= 16'h0000;
      end else begin
         if (state != ST_DONE || cal_req) begin
            dly_count <= 16'h0000;
            dly_done  <= 1'b0;
         end else if (dly_count >= lock_delay_count) begin
            dly_done  <= 1'b1;
         end else if (pd_edge) begin
            dly_count <= dly_count + 16'h0001;
         end
         if (lock_ok || state != ST_DONE || !dly_done || recal_fire)
            unlock_count <= 16'h0000;
         else if (pd_edge && unlock_count != 16'hffff)
            unlock_count <= unlock_count + 16'h0001;
      end
   end
   // Loss of lock lasting the lock delay
   assign recal_fire = relock_recal_enable && dly_done && !lock_ok && !cal_req &&
                       (unlock_count >= lock_delay_count) && (state == ST_DONE);

   assign cal_ind = (state == ST_DONE) & dly_done & ~cal_req;

   // Combined indicator, held while the reference is missing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         combined          <= 1'b0;
         shared_status_pin <= 1'b0;
         output_mute       <= 1'b0;
      end else begin
         if (busy || cal_req)
            combined <= 1'b0;
         else if (ref_valid)
            combined <= cal_ind & lock_ok;
         if (!ctrl[`CTRL_STATUS_SEL])
            shared_status_pin <= readback_data;
         else
            shared_status_pin <= lock_indicator_select ? combined : cal_ind;
         output_mute <= ctrl[`CTRL_MUTE_BIT] & ~combined;
      end
   end

   // Interrupts: sticky, cleared by reading, set wins
   assign ev[`IRQ_CAL_DONE]   = sm_tick & (state == ST_AMP) & (next_state == ST_DONE);
   assign ev[`IRQ_WD_RESTART] = sm_tick & busy & wd_expire & (next_state == ST_BAND);
   assign ev[`IRQ_WD_FAIL]    = sm_tick & busy & (next_state == ST_FAIL);
   assign ev[`IRQ_LOCK_LOST]  = combined & ~lock_ok & ref_valid;
   assign ev[`IRQ_RECAL]      = recal_fire;
   assign irq = |(irq_stat & irq_mask);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_stat <= {`IRQ_WIDTH{1'b0}};
      else if (rd && paddr == `REG_IRQ_STAT)
         irq_stat <= ev;
      else
         irq_stat <= irq_stat | ev;
   end

   // Read mux
   always @* begin
      case (paddr)
         `REG_CTRL:     prdata = ctrl;
         `REG_CORE:     prdata = {29'h0, core_start};
         `REG_BAND:     prdata = {24'h0, band_value};
         `REG_AMP:      prdata = {23'h0, amplitude_value};
         `REG_LOCK_DLY: prdata = {16'h0, lock_delay_count};
         `REG_LOCK_CFG: prdata = {31'h0, lock_indicator_select};
         `REG_STATUS:   prdata = {23'h0, restart_count, ref_valid, lock_ok, combined, cal_ind, state == ST_FAIL, busy};
         `REG_IRQ_STAT: prdata = {27'h0, irq_stat};
         `REG_IRQ_MASK: prdata = {27'h0, irq_mask};
         `REG_RESULT:   prdata = {8'h00, core_sel, 1'b0, band_sel, 3'h0, amp_sel};
         default:       prdata = 32'h0000_0000;
      endcase
   end
endmodule

// file: vco_calibration_lock_detect_checker.sv
`timescale 1ns/1ps
module vco_calibration_lock_detect_checker (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Analog and status
   input wire logic        pll_locked,
   input wire logic        shared_status_pin,
   input wire logic        output_mute,
   input wire logic [2:0]  core_sel,
   input wire logic [7:0]  band_sel,
   input wire logic [8:0]  amp_sel,
   input wire logic        irq
);
   logic [31:0] ctrl_q;
   logic        cfg_q;
   logic [2:0]  core_q;
   logic [7:0]  band_q;
   logic [8:0]  amp_q;
   logic        wr;
   logic        comb_view;
   assign wr = psel && penable && pwrite && pready;
   assign comb_view = ctrl_q[2] && cfg_q;
   // Shadow of the host settings, so the checks need no internal probes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 32'h0;
         cfg_q  <= 1'b0;
         core_q <= 3'h7;
         band_q <= 8'h0;
         amp_q  <= 9'h0;
      end else if (wr) begin
         if (paddr == 8'h00) ctrl_q <= pwdata;
         if (paddr == 8'h14) cfg_q <= pwdata[0];
         if (paddr == 8'h04) core_q <= pwdata[2:0];
         if (paddr == 8'h08) band_q <= pwdata[7:0];
         if (paddr == 8'h0c) amp_q <= pwdata[8:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_fixed: assert property (pready && !pslverr) else $error("apb answer not zero wait");
   a_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 8'h24 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_cal_pin_low: assert property (wr && paddr == 8'h00 && pwdata[0] && pwdata[2] |-> ##3 !shared_status_pin)
      else $error("status pin high during calibration");
   a_mute_on: assert property ((ctrl_q[9] && comb_view && !shared_status_pin) [*3] |-> output_mute)
      else $error("output not muted");
   a_mute_off: assert property ((!ctrl_q[9]) [*3] |-> !output_mute) else $error("mute without enable");
   a_pin_needs_lock: assert property (comb_view && $rose(shared_status_pin) |-> $past(pll_locked, 2))
      else $error("combined indicator rose without lock");
   a_irq_mask_off: assert property (wr && paddr == 8'h20 && pwdata[4:0] == 5'h0 |-> ##1 (!irq) [*2])
      else $error("irq high with mask clear");
   a_core_forced: assert property (wr && paddr == 8'h00 && pwdata[20] |-> ##[1:40] core_sel == core_q)
      else $error("forced core not applied");
   a_band_forced: assert property (wr && paddr == 8'h00 && pwdata[21] |-> ##[1:40] band_sel == band_q)
      else $error("forced band not applied");
   a_amp_forced: assert property (wr && paddr == 8'h00 && pwdata[22] |-> ##[1:40] amp_sel == amp_q)
      else $error("forced amplitude not applied");
   c_trigger: cover property (wr && paddr == 8'h00 && pwdata[0]);
   c_pin_rise: cover property ($rose(shared_status_pin));
   c_irq_rise: cover property ($rose(irq));
endmodule

// file: analog_side_model.sv
`timescale 1ns/1ps
module analog_side_model #(
   parameter logic [7:0] BAND_TARGET = 8'h40
) (
   // Control from bench, band select from the block
   input wire logic       pclk,
   input wire logic       ref_run,
   input wire logic       lock_in,
   input wire logic       amp_stuck,
   input wire logic [7:0] band_sel,
   // Toward the block
   output logic           reference_input,
   output logic           pd_tick,
   output logic           pll_locked,
   output logic           band_high,
   output logic           amp_ok
);
   logic [2:0] cnt = 3'h0;
   // Clocks stand still while the reference is withdrawn
   always @(posedge pclk) begin
      if (ref_run) cnt <= cnt + 3'h1;
   end
   assign reference_input = cnt[1];
   assign pd_tick = cnt[2];
   assign pll_locked = lock_in;
   // A stuck run also pins the band flag, so only the watchdog can end a run that searches bands
   assign band_high = (band_sel < BAND_TARGET) || amp_stuck;
   assign amp_ok = !amp_stuck;
endmodule

// file: vco_calibration_lock_detect_bench.sv
`timescale 1ns/1ps
`include "vco_cal_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module vco_calibration_lock_detect_bench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        pready, pslverr, reference_input, pd_tick, pll_locked, band_high, amp_ok;
   logic        relock = 0, ref_run = 0, lock_in = 0, amp_stuck = 0;
   logic        shared_status_pin, output_mute, irq;
   logic [2:0]  core_sel;
   logic [7:0]  band_sel;
   logic [8:0]  amp_sel;
   int          err_count = 0, cmp_count = 0;
   always #2 pclk = ~pclk;
   analog_side_model model (.pclk(pclk), .ref_run(ref_run), .lock_in(lock_in), .amp_stuck(amp_stuck),
      .band_sel(band_sel), .reference_input(reference_input), .pd_tick(pd_tick), .pll_locked(pll_locked),
      .band_high(band_high), .amp_ok(amp_ok));
   vco_calibration_lock_detect dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reference_input(reference_input), .pd_tick(pd_tick), .pll_locked(pll_locked), .band_high(band_high),
      .amp_ok(amp_ok), .relock_recal_enable(relock), .readback_data(1'b0),
      .shared_status_pin(shared_status_pin), .output_mute(output_mute), .core_sel(core_sel),
      .band_sel(band_sel), .amp_sel(amp_sel), .irq(irq));
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin err_count++; tally_and_finish; end
      rdv = prdata;
      psel <= 0; penable <= 0;
   endtask
   task wait_bit(input logic [7:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin apb(0, a, 0); n++; end while (rdv[b] !== v && n < 20000);
      if (rdv[b] !== v) begin err_count++; tally_and_finish; end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      `CHK(core_sel, 3'h7)
      `CHK(output_mute, 1'b0)
      apb(0, `REG_CORE, 0); `CHK(rdv[2:0], 3'h7)
      apb(0, `REG_LOCK_DLY, 0); `CHK(rdv, 32'h0)
      apb(1, 8'h3c, 32'hffff_ffff); apb(0, 8'h3c, 0); `CHK(rdv, 32'h0)
      ref_run <= 1; lock_in <= 1;
      repeat (300) @(posedge pclk);
      apb(1, `REG_LOCK_DLY, 4); apb(1, `REG_LOCK_CFG, 1); apb(1, `REG_IRQ_MASK, 32'h1f);
      apb(1, `REG_CORE, 7);
      apb(1, `REG_CTRL, 32'h0000_0205);
      wait_bit(`REG_STATUS, 0, 0);
      `CHK(band_sel, 8'h40)
      repeat (80) @(posedge pclk);
      `CHK(shared_status_pin, 1'b1)
      `CHK(output_mute, 1'b0)
      `CHK(irq, 1'b1)
      apb(1, `REG_IRQ_MASK, 0); @(posedge pclk); `CHK(irq, 1'b0)
      apb(1, `REG_IRQ_MASK, 32'h1f); apb(0, `REG_IRQ_STAT, 0); `CHK(rdv[0], 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      lock_in <= 0; repeat (20) @(posedge pclk);
      `CHK(shared_status_pin, 1'b0)
      `CHK(output_mute, 1'b1)
      lock_in <= 1; repeat (20) @(posedge pclk);
      `CHK(shared_status_pin, 1'b1)
      ref_run <= 0; repeat (300) @(posedge pclk);
      lock_in <= 0; repeat (20) @(posedge pclk);
      `CHK(shared_status_pin, 1'b1)
      ref_run <= 1; repeat (300) @(posedge pclk);
      `CHK(shared_status_pin, 1'b0)
      apb(1, `REG_LOCK_CFG, 0); repeat (10) @(posedge pclk);
      `CHK(shared_status_pin, 1'b1)
      lock_in <= 1; repeat (20) @(posedge pclk);
      apb(1, `REG_LOCK_CFG, 1);
      amp_stuck <= 1;
      apb(1, `REG_CTRL, 32'h0000_0204); apb(0, `REG_STATUS, 0); `CHK(rdv[0], 1'b1)
      `CHK(band_sel, 8'h40)
      amp_stuck <= 0; wait_bit(`REG_STATUS, 0, 0);
      apb(1, `REG_CORE, 3); apb(1, `REG_BAND, 8'h5a); apb(1, `REG_AMP, 9'h123);
      apb(1, `REG_CTRL, 32'h0070_0205); wait_bit(`REG_STATUS, 0, 0);
      `CHK(core_sel, 3'h3)
      `CHK(band_sel, 8'h5a)
      `CHK(amp_sel, 9'h123)
      repeat (80) @(posedge pclk);
      relock <= 1; lock_in <= 0;
      wait_bit(`REG_IRQ_STAT, `IRQ_RECAL, 1);
      lock_in <= 1; relock <= 0; wait_bit(`REG_STATUS, 0, 0);
      apb(1, `REG_CORE, 7); amp_stuck <= 1;
      apb(1, `REG_CTRL, 32'h0002_0405);
      wait_bit(`REG_STATUS, 1, 1); `CHK(rdv[8:6], 3'h2)
      apb(0, `REG_IRQ_STAT, 0); `CHK(rdv[2:1], 2'h3)
      amp_stuck <= 0; apb(1, `REG_CORE, 1);
      apb(1, `REG_CTRL, 32'h0002_0405); apb(0, `REG_STATUS, 0); `CHK(rdv[8:6], 3'h0)
      wait_bit(`REG_STATUS, 0, 0); `CHK(core_sel, 3'h1)
      tally_and_finish;
   end
endmodule
bind vco_calibration_lock_detect vco_calibration_lock_detect_checker chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked), .shared_status_pin(shared_status_pin),
   .output_mute(output_mute), .core_sel(core_sel), .band_sel(band_sel), .amp_sel(amp_sel), .irq(irq));
